/* design/mie_pkg.sv */
package mie_pkg;

  localparam int INSTR_W  = 14;
  localparam int PC_W     = 15;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int LATCH_W  = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BUS_AW   = 8;
  localparam int BUS_DW   = 32;

  // opcode patterns; the _HI constants are compared on the upper bits they name, the others on the whole word
  localparam logic [INSTR_W-1:0] OPC_WATCHDOG_CLEAR = 14'h0064;
  localparam logic [INSTR_W-1:0] OPC_CALL_VIA_WORK  = 14'h000A;
  localparam logic [6:0]         OPC_CLEAR_WORK_HI  = 7'h02;
  localparam logic [6:0]         OPC_CLEAR_FILE_HI  = 7'h03;
  localparam logic [5:0]         OPC_COMPLEMENT_HI  = 6'h09;
  localparam logic [5:0]         OPC_DECREMENT_HI   = 6'h03;
  localparam logic [5:0]         OPC_DEC_SKIP_HI    = 6'h0B;
  localparam int                 DEST_BIT           = 7;

  // register byte offsets
  localparam logic [BUS_AW-1:0] REG_INSTR  = 8'h00;
  localparam logic [BUS_AW-1:0] REG_WORK   = 8'h04;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [BUS_AW-1:0] REG_PC     = 8'h0C;
  localparam logic [BUS_AW-1:0] REG_LATCH  = 8'h10;
  localparam logic [BUS_AW-1:0] REG_STACK  = 8'h14;
  localparam logic [BUS_AW-1:0] REG_FADDR  = 8'h18;
  localparam logic [BUS_AW-1:0] REG_FDATA  = 8'h1C;

  // status field positions
  localparam int ST_ZERO    = 0;
  localparam int ST_PDOWN   = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int STATUS_W   = 3;

  // reset values
  localparam logic [DATA_W-1:0]  RST_WORK    = 8'h00;
  localparam logic [PC_W-1:0]    RST_PC      = 15'h0000;
  localparam logic [LATCH_W-1:0] RST_LATCH   = 7'h00;
  localparam logic [INSTR_W-1:0] RST_INSTR   = 14'h0000;
  localparam logic               RST_ZERO    = 1'b0;
  localparam logic               RST_PDOWN   = 1'b1;
  localparam logic               RST_TIMEOUT = 1'b1;

  localparam logic [PC_W-1:0]   PC_STEP   = 15'h0001;
  localparam logic [PC_W-1:0]   PC_SKIP   = 15'h0002;
  localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_SECOND = 2'b10,
    ST_DONE   = 2'b11
  } mie_state_t;

endpackage

/* design/mie_file_if.sv */
`timescale 1ns/1ps
interface mie_file_if #(parameter int AW = 7, parameter int DW = 8);
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport core (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport ram  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

/* design/mie_file_ram.sv */
`timescale 1ns/1ps
module mie_file_ram
  import mie_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH
) (
  input wire logic  clk,
  mie_file_if.ram   port
);

  // data storage, no reset: contents are undefined until written
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  // read is combinational so an operation reads and writes in one cycle
  assign port.rd_data = mem[port.rd_addr];

endmodule

/* design/mie_exec_core.sv */
`timescale 1ns/1ps
// Overview of operation
// RQ1 - watchdog clear zeroes the watchdog counter and its prescaler; no operands.
// RQ2 - watchdog clear sets timeout and power-down flags; other status bits untouched.
// RQ3 - call via work first pushes pc plus one as new stack top.
// RQ4 - then pc low byte from work, pc bits 14:8 from latch 6:0.
// RQ5 - call via work takes two cycles and changes no status flag.
// RQ6 - destination bit 0 writes work, 1 writes back file; file address 0..127.
// RQ7 - complement inverts the file byte, goes to destination, updates zero flag.
// RQ8 - clear file writes zero to the file register and sets zero flag.
// RQ9 - clear work writes zero to work and sets zero flag; no operands.
// RQ10 - decrement subtracts one, goes to destination, updates zero flag.
// RQ11 - decrement-skip touches no flag; zero result skips next word, two cycles.
// RQ12 - non-branching operations and non-skipping decrement-skip take one cycle.
module mie_exec_core
  import mie_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_DW-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [BUS_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   watchdog_counter_clear,
  output logic                   watchdog_prescaler_clear,
  output logic                   stack_push,
  output logic      [PC_W-1:0]   stack_top_entry,
  output logic      [PC_W-1:0]   program_counter
);

  mie_state_t           state;
  mie_state_t           next_state;
  logic [INSTR_W-1:0]   instr;
  logic [DATA_W-1:0]    work;
  logic                 zero;
  logic                 power_down_flag;
  logic                 timeout_flag;
  logic [LATCH_W-1:0]   pc_high_latch;
  logic [FADDR_W-1:0]   file_addr;

  mie_file_if #(.AW(FADDR_W), .DW(DATA_W)) fr ();

  mie_file_ram #(.DEPTH(FILE_DEPTH)) u_file_ram (
    .clk  (clk),
    .port (fr)
  );

  // bus decode; a request is only taken in idle, so bus and execution never overlap
  wire logic              in_idle      = (state == ST_IDLE);
  wire logic              in_exec      = (state == ST_EXEC);
  wire logic              in_second    = (state == ST_SECOND);
  wire logic              bus_req      = avs_read | avs_write;
  wire logic              sw_wr        = in_idle & avs_write & avs_byteenable[0];
  wire logic              sw_rd        = in_idle & avs_read;
  wire logic              instr_submit = sw_wr & (avs_address == REG_INSTR);
  wire logic              wr_work      = sw_wr & (avs_address == REG_WORK);
  wire logic              wr_status    = sw_wr & (avs_address == REG_STATUS);
  wire logic              wr_pc        = sw_wr & (avs_address == REG_PC);
  wire logic              wr_latch     = sw_wr & (avs_address == REG_LATCH);
  wire logic              wr_faddr     = sw_wr & (avs_address == REG_FADDR);
  wire logic              wr_fdata     = sw_wr & (avs_address == REG_FDATA);
  wire logic [DATA_W-1:0] wdata_byte   = avs_writedata[DATA_W-1:0];

  // instruction decode
  wire logic               is_wdt_clear  = (instr == OPC_WATCHDOG_CLEAR);
  wire logic               is_call_work  = (instr == OPC_CALL_VIA_WORK);
  wire logic               is_clear_work = (instr[INSTR_W-1:DEST_BIT] == OPC_CLEAR_WORK_HI);
  wire logic               is_clear_file = (instr[INSTR_W-1:DEST_BIT] == OPC_CLEAR_FILE_HI);
  wire logic               is_complement = (instr[INSTR_W-1:DEST_BIT+1] == OPC_COMPLEMENT_HI);
  wire logic               is_decrement  = (instr[INSTR_W-1:DEST_BIT+1] == OPC_DECREMENT_HI);
  wire logic               is_dec_skip   = (instr[INSTR_W-1:DEST_BIT+1] == OPC_DEC_SKIP_HI);
  wire logic [FADDR_W-1:0] opnd_file     = instr[FADDR_W-1:0];
  wire logic               dest_file     = instr[DEST_BIT];

  // datapath
  wire logic [DATA_W-1:0] file_data  = fr.rd_data;
  wire logic [DATA_W-1:0] comp_res   = ~file_data;                                // [RQ7]
  wire logic [DATA_W-1:0] dec_res    = file_data - DATA_ONE;                      // [RQ10] [RQ11]
  wire logic [DATA_W-1:0] alu_res    = is_complement ? comp_res : dec_res;
  wire logic              alu_op     = is_complement | is_decrement | is_dec_skip;
  wire logic              alu_zero   = (alu_res == DATA_ZERO);
  wire logic              skip_taken = is_dec_skip & (dec_res == DATA_ZERO);      // [RQ11]
  wire logic              two_cycle  = is_call_work | skip_taken;                 // [RQ5] [RQ11] [RQ12]
  wire logic              exec_alu   = in_exec & alu_op;

  // file port: operand address while executing, software window otherwise
  assign fr.rd_addr = in_exec ? opnd_file : file_addr;
  assign fr.wr_addr = in_exec ? opnd_file : file_addr;
  assign fr.wr_en   = in_exec ? ((alu_op & dest_file) | is_clear_file) : wr_fdata; // [RQ6] [RQ8]
  assign fr.wr_data = in_exec ? (is_clear_file ? DATA_ZERO : alu_res) : wdata_byte; // [RQ8]

  // next values
  wire logic [DATA_W-1:0] next_work =
    wr_work                          ? wdata_byte :
    (in_exec & is_clear_work)        ? DATA_ZERO  :                               // [RQ9]
    (exec_alu & ~dest_file)          ? alu_res    :                               // [RQ6]
    work;

  // decrement-skip and call leave the zero flag alone
  wire logic next_zero =
    wr_status                                      ? avs_writedata[ST_ZERO] :
    (in_exec & (is_clear_file | is_clear_work))    ? 1'b1                   :     // [RQ8] [RQ9]
    (in_exec & (is_complement | is_decrement))     ? alu_zero               :     // [RQ7] [RQ10]
    zero;

  wire logic next_timeout =
    wr_status                ? avs_writedata[ST_TIMEOUT] :
    (in_exec & is_wdt_clear) ? 1'b1                      :                        // [RQ2]
    timeout_flag;

  wire logic next_power_down =
    wr_status                ? avs_writedata[ST_PDOWN] :
    (in_exec & is_wdt_clear) ? 1'b1                    :                          // [RQ2]
    power_down_flag;

  // call holds pc in its first cycle so the push sees the return address
  wire logic [PC_W-1:0] next_pc =
    wr_pc                        ? avs_writedata[PC_W-1:0]  :
    (in_exec & is_call_work)     ? program_counter          :
    (in_exec & skip_taken)       ? program_counter + PC_SKIP :                    // [RQ11]
    in_exec                      ? program_counter + PC_STEP :                    // [RQ12]
    (in_second & is_call_work)   ? {pc_high_latch, work}    :                     // [RQ4]
    program_counter;

  wire logic [PC_W-1:0] next_stack_top =
    (in_exec & is_call_work) ? program_counter + PC_STEP : stack_top_entry;       // [RQ3]

  wire logic [STATUS_W-1:0] status_word;
  assign status_word[ST_ZERO]    = zero;
  assign status_word[ST_PDOWN]   = power_down_flag;
  assign status_word[ST_TIMEOUT] = timeout_flag;

  // unmapped addresses read as zero and ignore writes
  wire logic [BUS_DW-1:0] rd_mux =
    (avs_address == REG_INSTR)  ? BUS_DW'(instr)           :
    (avs_address == REG_WORK)   ? BUS_DW'(work)            :
    (avs_address == REG_STATUS) ? BUS_DW'(status_word)     :
    (avs_address == REG_PC)     ? BUS_DW'(program_counter) :
    (avs_address == REG_LATCH)  ? BUS_DW'(pc_high_latch)   :
    (avs_address == REG_STACK)  ? BUS_DW'(stack_top_entry) :
    (avs_address == REG_FADDR)  ? BUS_DW'(file_addr)       :
    (avs_address == REG_FDATA)  ? BUS_DW'(file_data)       :
    '0;

  always_comb begin
    case (state)
      ST_IDLE: begin
        if (instr_submit) begin
          next_state = ST_EXEC;
        end else if (bus_req) begin
          next_state = ST_DONE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_EXEC:   next_state = two_cycle ? ST_SECOND : ST_DONE;                    // [RQ5] [RQ12]
      ST_SECOND: next_state = ST_DONE;
      ST_DONE:   next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      state           <= next_state;
      avs_waitrequest <= (next_state != ST_DONE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr           <= RST_INSTR;
      work            <= RST_WORK;
      zero            <= RST_ZERO;
      timeout_flag    <= RST_TIMEOUT;
      power_down_flag <= RST_PDOWN;
      program_counter <= RST_PC;
      pc_high_latch   <= RST_LATCH;
      file_addr       <= '0;
    end else begin
      instr           <= instr_submit ? avs_writedata[INSTR_W-1:0] : instr;
      work            <= next_work;
      zero            <= next_zero;
      timeout_flag    <= next_timeout;
      power_down_flag <= next_power_down;
      program_counter <= next_pc;
      pc_high_latch   <= wr_latch ? wdata_byte[LATCH_W-1:0] : pc_high_latch;
      file_addr       <= wr_faddr ? wdata_byte[FADDR_W-1:0] : file_addr;
    end
  end

  // clear and push outputs are one-cycle pulses; the counter itself lives elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter_clear   <= 1'b0;
      watchdog_prescaler_clear <= 1'b0;
      stack_push               <= 1'b0;
      stack_top_entry          <= RST_PC;
      avs_readdata             <= '0;
    end else begin
      watchdog_counter_clear   <= in_exec & is_wdt_clear;                         // [RQ1]
      watchdog_prescaler_clear <= in_exec & is_wdt_clear;                         // [RQ1]
      stack_push               <= in_exec & is_call_work;                         // [RQ3]
      stack_top_entry          <= next_stack_top;
      avs_readdata             <= sw_rd ? rd_mux : avs_readdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_call_start;
    in_exec && is_call_work;
  endsequence

  sequence s_call_finish;
    in_second ##1 (state == ST_DONE);
  endsequence

  a_wdt_clear_pulse: assert property ( // [RQ1]
    (in_exec && is_wdt_clear) |=> (watchdog_counter_clear && watchdog_prescaler_clear)
      ##1 (!watchdog_counter_clear && !watchdog_prescaler_clear))
    else $error("watchdog clear pulses wrong");

  a_wdt_flags_set: assert property ( // [RQ2]
    (in_exec && is_wdt_clear) |=> (timeout_flag && power_down_flag && zero == $past(zero)))
    else $error("watchdog clear flags wrong");

  a_call_push_value: assert property ( // [RQ3]
    s_call_start |=> (stack_push && stack_top_entry == $past(program_counter) + PC_STEP))
    else $error("call return address wrong");

  a_call_target_load: assert property ( // [RQ4]
    s_call_start |=> in_second ##1 (program_counter == {$past(pc_high_latch), $past(work)}))
    else $error("call target wrong");

  a_call_two_cycles: assert property ( // [RQ5]
    s_call_start |=> s_call_finish ##0 (zero == $past(zero, 2) && timeout_flag == $past(timeout_flag, 2)
      && power_down_flag == $past(power_down_flag, 2)))
    else $error("call timing or flags wrong");

  a_dest_file_write: assert property ( // [RQ6]
    (exec_alu && dest_file) |-> (fr.wr_en && fr.wr_addr == opnd_file && fr.wr_data == alu_res)
      ##1 (work == $past(work)))
    else $error("file destination wrong");

  a_complement_result: assert property ( // [RQ7]
    (in_exec && is_complement && !dest_file) |=>
      (work == ~$past(file_data) && zero == (work == DATA_ZERO)))
    else $error("complement result wrong");

  a_clear_file_zero: assert property ( // [RQ8]
    (in_exec && is_clear_file) |-> (fr.wr_en && fr.wr_data == DATA_ZERO) ##1 zero)
    else $error("clear file wrong");

  a_clear_work_zero: assert property ( // [RQ9]
    (in_exec && is_clear_work) |=> (work == DATA_ZERO && zero))
    else $error("clear work wrong");

  a_decrement_result: assert property ( // [RQ10]
    (in_exec && is_decrement && !dest_file) |=>
      (work == $past(file_data) - DATA_ONE && zero == (work == DATA_ZERO)))
    else $error("decrement result wrong");

  a_skip_taken_path: assert property ( // [RQ11]
    (in_exec && skip_taken) |=>
      (in_second && program_counter == $past(program_counter) + PC_SKIP && zero == $past(zero)))
    else $error("skip path wrong");

  a_single_cycle_ops: assert property ( // [RQ12]
    (in_exec && !two_cycle) |=>
      (state == ST_DONE && !avs_waitrequest && program_counter == $past(program_counter) + PC_STEP))
    else $error("single cycle op wrong");

  // side effects that the result checks above would miss
  // a stray write or pulse here corrupts state that software never reads back

  sequence s_skip_nop;
    in_second && !fr.wr_en ##1 (state == ST_DONE);
  endsequence

  sequence s_bus_answer;
    (state == ST_DONE) ##1 avs_waitrequest;
  endsequence

  a_wdt_pulse_source: assert property ( // [RQ1]
    watchdog_prescaler_clear |-> ($past(in_exec) && $past(is_wdt_clear)))
    else $error("watchdog clear pulse without instruction");

  a_push_only_call: assert property ( // [RQ3]
    stack_push |-> ($past(in_exec) && $past(is_call_work)))
    else $error("push without call");

  a_stack_top_kept: assert property ( // [RQ3]
    !(in_exec && is_call_work) |=> (stack_top_entry == $past(stack_top_entry)))
    else $error("stack top changed without push");

  a_call_holds_pc: assert property ( // [RQ4]
    s_call_start |=> (program_counter == $past(program_counter)))
    else $error("call moved pc before target load");

  a_skip_second_nop: assert property ( // [RQ11]
    (in_exec && skip_taken) |=> s_skip_nop ##0
      (work == $past(work) && program_counter == $past(program_counter)))
    else $error("skip second cycle not a no-operation");

  a_skip_flags_kept: assert property ( // [RQ11]
    (in_exec && is_dec_skip) |=> (zero == $past(zero) && timeout_flag == $past(timeout_flag)
      && power_down_flag == $past(power_down_flag)))
    else $error("decrement skip touched a flag");

  a_no_skip_single: assert property ( // [RQ12]
    (in_exec && is_dec_skip && !skip_taken) |=>
      (state == ST_DONE && program_counter == $past(program_counter) + PC_STEP))
    else $error("nonzero decrement skip not single cycle");

  a_dest_work_write: assert property ( // [RQ6]
    (exec_alu && !dest_file) |-> !fr.wr_en ##1 (work == $past(alu_res)))
    else $error("work destination wrong");

  a_complement_file: assert property ( // [RQ7]
    (in_exec && is_complement && dest_file) |-> (fr.wr_en && fr.wr_data == ~file_data)
      ##1 (zero == ($past(comp_res) == DATA_ZERO)))
    else $error("complement to file wrong");

  a_decrement_file: assert property ( // [RQ10]
    (in_exec && is_decrement && dest_file) |-> (fr.wr_en && fr.wr_data == file_data - DATA_ONE)
      ##1 (zero == ($past(file_data) == DATA_ONE)))
    else $error("decrement to file wrong");

  a_clear_file_work_kept: assert property ( // [RQ8]
    (in_exec && is_clear_file) |=> (work == $past(work)))
    else $error("clear file changed work");

  a_clear_work_no_file: assert property ( // [RQ9]
    (in_exec && is_clear_work) |-> !fr.wr_en)
    else $error("clear work wrote a file register");

  a_bus_answer_once: assert property ( // [RQ5] [RQ12]
    !avs_waitrequest |-> s_bus_answer)
    else $error("waitrequest low outside completion cycle");

endmodule

/* verif/mie_prog_mem.sv */
`timescale 1ns/1ps
module mie_prog_mem
  import mie_pkg::*;
(
  input  wire logic [PC_W-1:0]    pc,
  output logic      [INSTR_W-1:0] word
);
  // fixed little program; words past the end read as no-effect codes
  always_comb begin
    case (pc)
      15'h0000: word = 14'h0B85;
      15'h0001: word = OPC_WATCHDOG_CLEAR;
      15'h0002: word = 14'h0B85;
      15'h0003: word = OPC_WATCHDOG_CLEAR;
      15'h0004: word = {OPC_CLEAR_WORK_HI, 7'h00};
      15'h0005: word = OPC_CALL_VIA_WORK;
      default:  word = 14'h0000;
    endcase
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import mie_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [BUS_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [BUS_DW-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [BUS_DW-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              wdc;
  logic              wpc;
  logic              stack_push;
  logic [PC_W-1:0]   stack_top_entry;
  logic [PC_W-1:0]   pc;
  logic [INSTR_W-1:0] word;
  logic [BUS_DW-1:0] rq[$];
  logic [PC_W-1:0]   sq[$];
  int                n_mismatch;
  int                checks;
  int                n_wdc;

  always #12.5 clk = ~clk;

  mie_exec_core mie_exec_core_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .watchdog_counter_clear(wdc), .watchdog_prescaler_clear(wpc),
    .stack_push(stack_push), .stack_top_entry(stack_top_entry), .program_counter(pc)
  );
  mie_prog_mem mie_prog_mem_inst (.pc(pc), .word(word));

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // holds the request until waitrequest is seen low; n counts edges
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output int n);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bus(1'b1, a, d, n);
  endtask

  // the watcher compares read data against this note
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    rq.push_back(exp);
    bus(1'b0, a, 32'h0, n);
  endtask

  task automatic ex(input logic [13:0] w, output int n);
    bus(1'b1, REG_INSTR, {18'h0, w}, n);
  endtask

  always @(posedge clk) begin
    if (rst_n) begin
      if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) cmp32(avs_readdata, rq.pop_front(), "read");
      if (stack_push === 1'b1 && sq.size() > 0) cmp32(stack_top_entry, sq.pop_front(), "push");
      if (wdc !== wpc) cmp32(wpc, wdc, "prescaler clear");
      if (wdc === 1'b1) n_wdc++;
    end
  end

  initial begin
    #(25 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin : main
    logic [6:0]  f;
    logic [7:0]  v, w, r;
    logic [2:0]  s;
    logic        d, z;
    logic [13:0] iw;
    logic [14:0] p;
    logic [14:0] walk [5];
    int          n, n1, i, k, w0;
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(32'h74E0));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_STATUS, 32'h6);
    rd(REG_WORK, 32'h0);
    rd(REG_PC, 32'h0);
    wr(REG_STATUS, 32'h1);
    ex(OPC_WATCHDOG_CLEAR, n1);
    rd(REG_STATUS, 32'h7);
    cmp32(n_wdc, 1, "watchdog pulses");
    // k: complement, decrement, clear file, clear work; i 0/1 hit the zero and wrap edges
    for (i = 0; i < 6; i++) begin
      for (k = 0; k < 4; k++) begin
        f = (i == 0) ? 7'h7F : 7'($urandom_range(0, 127));
        v = (i == 0) ? ((k == 0) ? 8'hFF : 8'h01) : (i == 1) ? 8'h00 : 8'($urandom);
        w = 8'($urandom);
        s = 3'($urandom);
        d = i[0];
        case (k)
          0: begin iw = {OPC_COMPLEMENT_HI, d, f}; r = ~v; end
          1: begin iw = {OPC_DECREMENT_HI, d, f}; r = v - DATA_ONE; end
          2: begin iw = {OPC_CLEAR_FILE_HI, f}; r = DATA_ZERO; end
          default: begin iw = {OPC_CLEAR_WORK_HI, 7'h00}; r = DATA_ZERO; end
        endcase
        z = (k > 1) ? 1'b1 : (r == 8'h00);
        wr(REG_FADDR, {25'h0, f});
        wr(REG_FDATA, {24'h0, v});
        wr(REG_WORK, {24'h0, w});
        wr(REG_STATUS, {29'h0, s});
        ex(iw, n);
        rd(REG_FDATA, {24'h0, (k == 2 || (k < 2 && d)) ? r : v});
        rd(REG_WORK, {24'h0, (k == 3 || (k < 2 && !d)) ? r : w});
        rd(REG_STATUS, {29'h0, s[2:1], z});
        cmp32(n, n1, "cycles");
      end
    end
    for (i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h01 : 8'h05;
      r = v - DATA_ONE;
      f = 7'($urandom_range(0, 127));
      d = 1'($urandom);
      w = 8'($urandom);
      s = 3'($urandom);
      p = 15'($urandom_range(0, 32'h7F00));
      wr(REG_PC, {17'h0, p});
      wr(REG_FADDR, {25'h0, f});
      wr(REG_FDATA, {24'h0, v});
      wr(REG_WORK, {24'h0, w});
      wr(REG_STATUS, {29'h0, s});
      ex({OPC_DEC_SKIP_HI, d, f}, n);
      rd(REG_PC, {17'h0, p + ((r == 8'h00) ? PC_SKIP : PC_STEP)});
      rd(REG_STATUS, {29'h0, s});
      rd(d ? REG_FDATA : REG_WORK, {24'h0, r});
      cmp32(n, n1 + ((r == 8'h00) ? 1 : 0), "skip cycles");
    end
    f = 7'($urandom);
    w = 8'($urandom);
    s = 3'($urandom);
    p = 15'($urandom_range(0, 32'h7F00));
    wr(REG_PC, {17'h0, p});
    wr(REG_LATCH, {25'h0, f});
    wr(REG_WORK, {24'h0, w});
    wr(REG_STATUS, {29'h0, s});
    sq.push_back(p + PC_STEP);
    ex(OPC_CALL_VIA_WORK, n);
    rd(REG_PC, {17'h0, f, w});
    rd(REG_STATUS, {29'h0, s});
    rd(REG_STACK, {17'h0, p + PC_STEP});
    cmp32(n, n1 + 1, "call cycles");
    // run the stored program: the skipped word must never clear the watchdog
    walk = '{15'h0001, 15'h0002, 15'h0004, 15'h0005, 15'h0000};
    w0 = n_wdc;
    wr(REG_FADDR, 32'h5);
    wr(REG_FDATA, 32'h2);
    wr(REG_LATCH, 32'h0);
    wr(REG_PC, 32'h0);
    for (i = 0; i < 5; i++) begin
      if (i == 4) sq.push_back(15'h0006);
      ex(word, n);
      rd(REG_PC, {17'h0, walk[i]});
    end
    cmp32(n_wdc - w0, 1, "skipped word");
    // lane 0 off and unmapped writes are ignored; an unknown word only steps pc
    w = 8'($urandom);
    wr(REG_WORK, {24'h0, w});
    avs_byteenable <= {3'($urandom), 1'b0};
    wr(REG_WORK, {24'h0, ~w});
    avs_byteenable <= 4'hF;
    wr(8'h20, {24'h0, ~w});
    rd(REG_WORK, {24'h0, w});
    p = 15'($urandom_range(0, 32'h7F00));
    wr(REG_PC, {17'h0, p});
    ex(14'h0000, n);
    rd(REG_PC, {17'h0, p + PC_STEP});
    cmp32(n, n1, "unknown word cycles");
    rd(8'h20, 32'h0);
    cmp32(rq.size() + sq.size(), 0, "pending notes");
    final_report();
  end
endmodule
